// file: core/link_csr_defines.vh
// Offsets, field positions, reset values and codes for the link control/status register
`ifndef LINK_CSR_DEFINES_VH
`define LINK_CSR_DEFINES_VH
`define LCS1_OFFSET 8'h08
`define LCS1_RESET 32'h80000000
`define LCS1_WMASK 32'hf8030001
`define B_LAMP 31
`define B_TX_DIS 30
`define B_DARK 29
`define B_LOOP 28
`define B_PAR_EN 27
`define B_REDUND 26
`define B_SCRUB1 25
`define B_SCRUB0 24
`define B_WIN1 22
`define B_CFG1 21
`define B_CFG0 20
`define B_WIN0 19
`define B_WDELAY 18
`define B_OFS1 17
`define B_OFS0 16
`define B_TXF_EMPTY 7
`define B_TXF_AFULL 6
`define B_RXF_FULL 5
`define B_RXF_AFULL 4
`define B_SYNC_LOSS 3
`define B_SIG_DET 2
`define B_BAD_DATA 1
`define B_OWN_DATA 0
`define SW_REDUND 0
`define SW_WDELAY 1
`define SW_WIN0 2
`define SW_WIN1 3
`define SW_SCRUB0 4
`define SW_SCRUB1 5
`define NET_ADDR_W 28
`define WDELAY_CYCLES 4'h8
`endif

// file: core/net_addr_offset.v
// Network address offset adder with wrap inside the network range
`timescale 1ns/1ps
`default_nettype none
`include "link_csr_defines.vh"
module net_addr_offset (
    input wire [`NET_ADDR_W-1:0] addr_i,
    input wire [1:0] offset_i,
    input wire apply_i,
    output wire [`NET_ADDR_W-1:0] addr_o
);
    wire [1:0] hi_sum;
    // Carry out of A27 is dropped so the address wraps
    assign hi_sum = addr_i[27:26] + offset_i;
    // Offset lands on A27..A26 only for local or received traffic
    assign addr_o = apply_i ? {hi_sum, addr_i[25:0]} : addr_i;
endmodule // net_addr_offset
`default_nettype wire

// file: core/link_csr.v
// Link control and status register with the steering it drives
//
// Overview of operation
// - Lamp field resets to one; writing zero turns the lamp off.
// - Transmitter disable field turns the transmitter off; resets to zero.
// - Dark-on-dark turns transmitter off on no signal or bad data.
// - Loopback disables optics and routes transmit back to receive.
// - Parity enable checks reads from memory on 32/64-bit accesses only.
// - With parity on, memory writes narrower than 32 bits are blocked.
// - Redundant transfer bit mirrors switch position one.
// - Scrub master 1 and 0 bits mirror switch positions six and five.
// - PIO window bits 22/19 mirror switch positions four and three.
// - Memory size bits 21/20 report installed memory size.
// - Write delay bit set holds back host write data.
// - Offset is added to A27/A26 of local and received packets only.
// - Carry beyond the network range is dropped, wrapping the address.
// - TX empty, TX almost-full, signal detect read live.
// - RX full, RX almost-full, bad data latch; cleared via irq flags.
// - Sync loss latches on loss of signal until cleared.
// - Own data latches on own packet return; readable and writable.
// - Bit 23 and bits 15..8 are reserved, read zero.
// - Irq flag fields stay set until host writes zero there.
`timescale 1ns/1ps
`default_nettype none
`include "link_csr_defines.vh"
module link_csr (
    input wire core_clk_i,
    input wire reset_i,
    // Register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    // Clears from the interrupt flag register, one pulse per bit
    input wire clr_rxf_full_i,
    input wire clr_rxf_afull_i,
    input wire clr_sync_loss_i,
    input wire clr_bad_data_i,
    // Straps and live status
    input wire [5:0] config_switch_bank_i,
    input wire [1:0] mem_size_i,
    input wire txf_empty_i,
    input wire txf_afull_i,
    input wire rxf_full_i,
    input wire rxf_afull_i,
    input wire sig_detect_i,
    input wire bad_data_i,
    input wire own_pkt_i,
    // Memory access qualification
    input wire mem_wr_i,
    input wire [3:0] mem_be_i,
    input wire mem_rd_i,
    input wire mem_par_err_i,
    // Address path
    input wire [`NET_ADDR_W-1:0] net_addr_i,
    input wire net_local_i,
    // Host write data path
    input wire host_wr_i,
    output reg host_wr_go_o,
    output reg mem_wr_ok_o,
    output reg mem_wr_inhibit_o,
    output reg par_err_o,
    output reg [`NET_ADDR_W-1:0] net_addr_o,
    output reg lamp_o,
    output reg tx_off_o,
    output reg rx_off_o,
    output reg loop_o
);
    localparam WD_IDLE = 2'b01;
    localparam WD_WAIT = 2'b10;

    reg [31:0] ctl_r;
    reg rxf_full_r, rxf_afull_r, sync_loss_r, bad_data_r, own_r;
    reg sig_det_d_r;
    reg [1:0] wd_state_r;
    reg [1:0] wd_state_nxt;
    reg [3:0] wd_cnt_r;
    wire [`NET_ADDR_W-1:0] addr_ofs;
    wire csr_wr;
    wire csr_rd;
    wire narrow_wr;
    wire [31:0] rd_word;

    // Full-word byte enables only count as a 32-bit access
    function is_narrow;
        input [3:0] be;
        begin
            is_narrow = (be != 4'hf);
        end
    endfunction

    assign csr_wr = reg_wr_i && (reg_addr_i == `LCS1_OFFSET);
    assign csr_rd = reg_rd_i && (reg_addr_i == `LCS1_OFFSET);
    assign narrow_wr = mem_wr_i && is_narrow(mem_be_i);

    // Writable control fields; reset puts lamp on, transmitter on
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            ctl_r <= `LCS1_RESET;
        end else if (csr_wr) begin
            ctl_r <= reg_wdata_i & `LCS1_WMASK;
        end
    end

    // Latched events; a new event beats a same-cycle clear
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            rxf_full_r <= 1'b0;
            rxf_afull_r <= 1'b0;
            sync_loss_r <= 1'b0;
            bad_data_r <= 1'b0;
            own_r <= 1'b0;
            sig_det_d_r <= 1'b0;
        end else begin
            sig_det_d_r <= sig_detect_i;
            // Only the interrupt flag register can clear these
            rxf_full_r <= rxf_full_i | (rxf_full_r & ~clr_rxf_full_i);
            rxf_afull_r <= rxf_afull_i | (rxf_afull_r & ~clr_rxf_afull_i);
            bad_data_r <= bad_data_i | (bad_data_r & ~clr_bad_data_i);
            // Falling signal detect marks a loss of sync
            sync_loss_r <= (sig_det_d_r & ~sig_detect_i) | (sync_loss_r & ~clr_sync_loss_i);
            // Own packet return sets; host zero write clears
            if (own_pkt_i) begin
                own_r <= 1'b1;
            end else if (csr_wr) begin
                own_r <= reg_wdata_i[`B_OWN_DATA];
            end
        end
    end

    // Read word; reserved bits tie to zero
    assign rd_word = {ctl_r[31:27],
                      config_switch_bank_i[`SW_REDUND],
                      config_switch_bank_i[`SW_SCRUB1],
                      config_switch_bank_i[`SW_SCRUB0],
                      1'b0,
                      config_switch_bank_i[`SW_WIN1],
                      mem_size_i,
                      config_switch_bank_i[`SW_WIN0],
                      config_switch_bank_i[`SW_WDELAY],
                      ctl_r[`B_OFS1:`B_OFS0],
                      8'h00,
                      txf_empty_i, txf_afull_i,
                      rxf_full_r, rxf_afull_r, sync_loss_r,
                      sig_detect_i,
                      bad_data_r, own_r};

    // Registered read data; holds last value between reads
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (csr_rd) begin
            reg_rdata_o <= rd_word;
        end
    end

    // Optics control outputs
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            lamp_o <= 1'b1;
            tx_off_o <= 1'b0;
            rx_off_o <= 1'b0;
            loop_o <= 1'b0;
        end else begin
            lamp_o <= ctl_r[`B_LAMP];
            // Manual, dark-on-dark or loopback each kill the laser
            tx_off_o <= ctl_r[`B_TX_DIS] | ctl_r[`B_LOOP] |
                        (ctl_r[`B_DARK] & (~sig_detect_i | bad_data_i));
            rx_off_o <= ctl_r[`B_LOOP];
            loop_o <= ctl_r[`B_LOOP];
        end
    end

    // Memory parity gating; partial writes cannot keep parity valid
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            mem_wr_ok_o <= 1'b0;
            mem_wr_inhibit_o <= 1'b0;
            par_err_o <= 1'b0;
        end else begin
            mem_wr_ok_o <= mem_wr_i & ~(ctl_r[`B_PAR_EN] & narrow_wr);
            mem_wr_inhibit_o <= ctl_r[`B_PAR_EN] & narrow_wr;
            par_err_o <= ctl_r[`B_PAR_EN] & mem_rd_i & ~is_narrow(mem_be_i) &
                         mem_par_err_i;
        end
    end

    net_addr_offset u_ofs (
        .addr_i(net_addr_i),
        .offset_i(ctl_r[`B_OFS1:`B_OFS0]),
        .apply_i(net_local_i),
        .addr_o(addr_ofs)
    );

    // Registered network address
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            net_addr_o <= {`NET_ADDR_W{1'b0}};
        end else begin
            net_addr_o <= addr_ofs;
        end
    end

    // Write delay machine; trades bandwidth for a fixed hold per write
    always @* begin
        wd_state_nxt = wd_state_r;
        case (wd_state_r)
            WD_IDLE: begin
                if (host_wr_i && config_switch_bank_i[`SW_WDELAY]) begin
                    wd_state_nxt = WD_WAIT;
                end
            end
            WD_WAIT: begin
                if (wd_cnt_r == 4'h1) begin
                    wd_state_nxt = WD_IDLE;
                end
            end
            default: begin
                wd_state_nxt = WD_IDLE;
            end
        endcase
    end

    // Delay counter and release pulse
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            wd_state_r <= WD_IDLE;
            wd_cnt_r <= 4'h0;
            host_wr_go_o <= 1'b0;
        end else begin
            wd_state_r <= wd_state_nxt;
            host_wr_go_o <= 1'b0;
            if (wd_state_r == WD_IDLE) begin
                wd_cnt_r <= `WDELAY_CYCLES;
                host_wr_go_o <= host_wr_i & ~config_switch_bank_i[`SW_WDELAY];
            end else begin
                wd_cnt_r <= wd_cnt_r - 4'h1;
                host_wr_go_o <= (wd_cnt_r == 4'h1);
            end
        end
    end
endmodule // link_csr
`default_nettype wire

// file: verif/link_csr_monitor.sv
// Port-level assertions for the link control and status register
`timescale 1ns/1ps
`default_nettype none
`include "link_csr_defines.vh"
module link_csr_monitor (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic mem_wr_i,
    input wire logic [3:0] mem_be_i,
    input wire logic mem_wr_ok_o,
    input wire logic mem_wr_inhibit_o,
    input wire logic host_wr_i,
    input wire logic host_wr_go_o,
    input wire logic [5:0] config_switch_bank_i,
    input wire logic [`NET_ADDR_W-1:0] net_addr_i,
    input wire logic net_local_i,
    input wire logic [`NET_ADDR_W-1:0] net_addr_o,
    input wire logic lamp_o,
    input wire logic tx_off_o,
    input wire logic rx_off_o,
    input wire logic loop_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // Register write hit, the cause of every control level
    wire logic hit = reg_wr_i && reg_addr_i == `LCS1_OFFSET;
    reset_out_a: assert property ($fell(reset_i) |-> lamp_o && !tx_off_o && !loop_o)
        else $error("outputs wrong after reset");
    lamp_off_a: assert property (hit && !reg_wdata_i[`B_LAMP] |-> ##[1:3] !lamp_o)
        else $error("lamp stayed on");
    tx_off_a: assert property (hit && reg_wdata_i[`B_TX_DIS] |-> ##[1:3] tx_off_o)
        else $error("transmitter stayed on");
    loop_on_a: assert property (hit && reg_wdata_i[`B_LOOP] |-> ##[1:3] loop_o && rx_off_o)
        else $error("loopback not entered");
    full_write_a: assert property (mem_wr_i && mem_be_i == 4'hf |=> mem_wr_ok_o)
        else $error("full word write refused");
    inhibit_cause_a: assert property (mem_wr_inhibit_o |-> $past(mem_be_i) != 4'hf)
        else $error("inhibit without narrow write");
    pass_thru_a: assert property (!net_local_i |=> net_addr_o == $past(net_addr_i))
        else $error("through address altered");
    no_delay_a: assert property (host_wr_i && !config_switch_bank_i[`SW_WDELAY] |=> host_wr_go_o)
        else $error("undelayed write late");
    with_delay_a: assert property (host_wr_i && config_switch_bank_i[`SW_WDELAY]
        |-> ##1 !host_wr_go_o [*8] ##1 host_wr_go_o) else $error("delayed write mistimed");
    reserved_zero_a: assert property (reg_rdata_o[23] == 1'h0 && reg_rdata_o[15:8] == 8'h0)
        else $error("reserved bits set");
endmodule // link_csr_monitor
bind link_csr link_csr_monitor i_mon (.*);
`default_nettype wire

// file: verif/ring_model.sv
// Ring partner: reports received light and returns own packets
`timescale 1ns/1ps
`default_nettype none
module ring_model (
    input wire logic core_clk_i,
    input wire logic link_up_i,
    input wire logic tx_off_i,
    input wire logic host_wr_go_i,
    output wire logic sig_detect_o,
    output wire logic own_pkt_o
);
    logic link_r = 1'h1;
    logic [2:0] trip_r = 3'h0;
    // A packet only comes back while light leaves and returns
    always @(posedge core_clk_i) begin
        link_r <= link_up_i;
        trip_r <= {trip_r[1:0], host_wr_go_i & ~tx_off_i & link_up_i};
    end
    assign sig_detect_o = link_r;
    assign own_pkt_o = trip_r[2];
endmodule // ring_model
`default_nettype wire

// file: verif/shared_memory_link_control_status_bench.sv
// Self-checking bench for the link control and status register
`timescale 1ns/1ps
`default_nettype none
`include "link_csr_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module shared_memory_link_control_status_bench;
    logic core_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, link_up = 1, host_wr_i = 0;
    logic [7:0] reg_addr_i = 8'h08;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, v, w;
    logic clr_rxf_full_i = 0, clr_rxf_afull_i = 0, clr_sync_loss_i = 0, clr_bad_data_i = 0;
    logic [5:0] config_switch_bank_i = '0;
    logic [1:0] mem_size_i = '0;
    logic txf_empty_i = 0, txf_afull_i = 0, rxf_full_i = 0, rxf_afull_i = 0, bad_data_i = 0;
    logic mem_wr_i = 0, mem_rd_i = 0, mem_par_err_i = 0, net_local_i = 0;
    logic [3:0] mem_be_i = '0;
    logic [27:0] net_addr_i = '0, net_addr_o;
    logic host_wr_go_o, mem_wr_ok_o, mem_wr_inhibit_o, par_err_o, lamp_o, tx_off_o, rx_off_o, loop_o;
    wire sig_detect_i, own_pkt_i;
    int error_cnt = 0, samples_checked = 0, n;
    link_csr i_dut (.*);
    ring_model i_ring (.core_clk_i(core_clk_i), .link_up_i(link_up), .tx_off_i(tx_off_o),
        .host_wr_go_i(host_wr_go_o), .sig_detect_o(sig_detect_i), .own_pkt_o(own_pkt_i));
    always #10 core_clk_i = ~core_clk_i;
    // Inputs always move 1 ns after the rising edge
    task automatic tick;
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr(input logic [31:0] d);
        reg_wdata_i = d;
        reg_wr_i = 1;
        tick;
        reg_wr_i = 0;
        repeat (2) tick;
    endtask
    task automatic rd(input logic [31:0] e);
        reg_rd_i = 1;
        tick;
        reg_rd_i = 0;
        `CHK(reg_rdata_o, e)
    endtask
    // Read image: writable bits, latched events, live straps and status
    function automatic logic [31:0] exp_rd(input logic [31:0] c, input logic [31:0] l);
        logic [5:0] s;
        s = config_switch_bank_i;
        exp_rd = (c & `LCS1_WMASK) | l | {5'h0, s[0], s[5], s[4], 1'h0, s[3], mem_size_i, s[2], s[1],
            10'h0, txf_empty_i, txf_afull_i, 3'h0, sig_detect_i, 2'h0};
    endfunction
    task automatic test_done;
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        v = $urandom(32'h38aa);
        repeat (5) tick;
        reset_i = 0;
        `CHK(lamp_o, 1'h1)
        `CHK(tx_off_o, 1'h0)
        rd(exp_rd(`LCS1_RESET, '0));
        repeat (6) begin
            v = $urandom;
            config_switch_bank_i = v[5:0];
            {mem_size_i, txf_empty_i, txf_afull_i} = v[9:6];
            w = $urandom;
            wr(w);
            rd(exp_rd(w, '0));
            `CHK({lamp_o, tx_off_o}, {w[31], w[30] | w[28]})
            `CHK({loop_o, rx_off_o}, {2{w[28]}})
        end
        // Events latch and hold until their clear pulse
        wr(32'ha0000000);
        {rxf_full_i, rxf_afull_i, bad_data_i, link_up} = 4'he;
        tick;
        {rxf_full_i, rxf_afull_i, bad_data_i} = 3'h0;
        repeat (3) tick;
        `CHK(tx_off_o, 1'h1)
        link_up = 1;
        repeat (3) tick;
        rd(exp_rd(32'ha0000000, 32'h3a));
        {clr_rxf_full_i, clr_rxf_afull_i, clr_sync_loss_i, clr_bad_data_i} = 4'hf;
        tick;
        {clr_rxf_full_i, clr_rxf_afull_i, clr_sync_loss_i, clr_bad_data_i} = 4'h0;
        rd(exp_rd(32'ha0000000, '0));
        for (int k = 0; k < 2; k++) begin
            config_switch_bank_i = {4'h0, k[0], 1'h0};
            wr(32'h80000000);
            rd(exp_rd(32'h80000000, '0));
            host_wr_i = 1;
            tick;
            host_wr_i = 0;
            n = 1;
            while (host_wr_go_o !== 1'h1 && n < 20) begin
                tick;
                n++;
            end
            `CHK(n, k ? 9 : 1)
            if (n >= 20)
                test_done;
            repeat (4) tick;
            rd(exp_rd(32'h80000000, 32'h1));
        end
        for (int p = 0; p < 2; p++) begin
            wr({1'h1, 3'h0, p[0], 27'h0});
            {mem_wr_i, mem_rd_i, mem_par_err_i} = 3'h7;
            for (int b = 0; b < 4; b++) begin
                mem_be_i = 4'hf >> (3 - b);
                tick;
                `CHK(mem_wr_inhibit_o, p[0] & (b != 3))
                `CHK(par_err_o, p[0] & (b == 3))
            end
            {mem_wr_i, mem_rd_i, mem_par_err_i} = 3'h0;
        end
        for (int o = 0; o < 4; o++) begin
            wr({1'h1, 13'h0, o[1:0], 16'h0});
            net_addr_i = 28'($urandom) | 28'hc000000;
            net_local_i = 1;
            tick;
            `CHK(net_addr_o, net_addr_i + {o[1:0], 26'h0})
            net_local_i = 0;
            tick;
            `CHK(net_addr_o, net_addr_i)
        end
        test_done;
    end
endmodule // shared_memory_link_control_status_bench
`default_nettype wire
